// ---- logic/ypk_pkg.sv ----
/*
  Shared constants for the 4:2:2 pixel packer: line geometry, conversion
  coefficients, rounding and saturation limits, chroma offset, enums.
  Assumes 8-bit raw mosaic samples in a blue-first (B G / G R) layout.
*/
`default_nettype none

package ypk_pkg;

  // =========================================================================
  // line geometry
  localparam int LINE_W = 2048;
  localparam int COL_W = 11;
  localparam logic [10:0] COL_ZERO = 11'h000;
  localparam logic [10:0] COL_ONE = 11'h001;

  // =========================================================================
  // conversion coefficients, scaled by 256
  localparam logic signed [9:0] Y_R = 10'h04D; // 0.30
  localparam logic signed [9:0] Y_G = 10'h097; // 0.59
  localparam logic signed [9:0] Y_B = 10'h01C; // 0.11
  localparam logic signed [9:0] U_R = 10'h3D4; // -0.17
  localparam logic signed [9:0] U_G = 10'h3AC; // -0.33
  localparam logic signed [9:0] U_B = 10'h080; // 0.50
  localparam logic signed [9:0] V_R = 10'h080; // 0.50
  localparam logic signed [9:0] V_G = 10'h397; // -0.41
  localparam logic signed [9:0] V_B = 10'h3E9; // -0.09

  // =========================================================================
  // rounding, limits and offset
  localparam logic signed [18:0] ROUND_HALF = 19'h00080;
  localparam int FRAC_BITS = 8;
  localparam logic signed [10:0] LUMA_LO = 11'h000;
  localparam logic signed [10:0] LUMA_HI = 11'h0FF;
  localparam logic signed [10:0] CHR_LO = 11'h780; // -128
  localparam logic signed [10:0] CHR_HI = 11'h07F; // +127
  localparam logic [7:0] CHR_OFFSET = 8'h80;

  // =========================================================================
  // types
  typedef enum logic [1:0] {KIND_BLUE, KIND_GREEN, KIND_RED} ypk_kind_e;
  typedef enum logic {SER_IDLE, SER_SECOND} ypk_ser_e;

endpackage

`default_nettype wire

// ---- logic/ypk_line_mem.sv ----
/*
  One-line store of raw mosaic samples, single port, read-before-write.
  Read data comes out of a register one clock after the address.
*/
`default_nettype none

module ypk_line_mem (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // access port
  input wire logic i_we,
  input wire logic [10:0] i_addr,
  input wire logic [7:0] i_wdata,
  // registered read data
  output logic [7:0] o_rdata
);

  logic [7:0] mem_q [ypk_pkg::LINE_W];
  logic [7:0] rdata_d;

  // =========================================================================
  // read path: old contents are returned even when the same word is written
  always_comb
  begin
    rdata_d = mem_q[i_addr];
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_rdata <= 8'h00;
    else
      o_rdata <= rdata_d;
  end

  // storage has no reset; a fresh frame starts on row 0 which never reads it
  always_ff @(posedge i_clk)
  begin
    if (i_we)
      mem_q[i_addr] <= i_wdata;
  end

endmodule // ypk_line_mem

`default_nettype wire

// ---- logic/ypk_packer.sv ----
/*
  Mosaic-to-YUV 4:2:2 byte packer: rebuilds RGB from a 2x2 window, converts
  to Y/U/V with rounding and saturation, and emits two bytes per pixel in
  standard (U Y V Y) or alternate (Y U Y V) order.
  Assumes the source honours o_pix_ready and marks line and frame starts.
*/
`default_nettype none

module ypk_packer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // raw mosaic pixels
  input wire logic i_pix_valid,
  input wire logic i_pix_sof,
  input wire logic i_pix_sol,
  input wire logic [7:0] i_pix_data,
  // byte order select, taken at frame start
  input wire logic i_fmt_yuyv,
  // pixel handshake
  output logic o_pix_ready,
  // packed byte stream
  output logic o_byte_valid,
  output logic [7:0] o_byte_data
);

  // =========================================================================
  // helper functions
  // colour under the mosaic at a given row/column parity
  function automatic ypk_pkg::ypk_kind_e bayer_kind(input logic py, input logic px);
    if (!py && !px)
      return ypk_pkg::KIND_BLUE;
    else if (py && px)
      return ypk_pkg::KIND_RED;
    else
      return ypk_pkg::KIND_GREEN;
  endfunction

  // weighted sum in 8.8 fixed point, with half an lsb added for rounding
  function automatic logic signed [18:0] mac(input logic signed [9:0] cr, input logic signed [9:0] cg,
                                             input logic signed [9:0] cb, input logic [7:0] r,
                                             input logic [7:0] g, input logic [7:0] b);
    logic signed [18:0] acc;
    acc = cr * $signed({1'b0, r});
    acc = acc + cg * $signed({1'b0, g});
    acc = acc + cb * $signed({1'b0, b});
    return acc + ypk_pkg::ROUND_HALF;
  endfunction

  // clamp to 0..255 so bright pixels never wrap to black
  function automatic logic [7:0] luma_byte(input logic signed [18:0] acc);
    logic signed [10:0] v;
    v = acc[18:ypk_pkg::FRAC_BITS];
    return (v < ypk_pkg::LUMA_LO) ? 8'h00 : ((v > ypk_pkg::LUMA_HI) ? 8'hFF : v[7:0]);
  endfunction

  // clamp to -128..+127, then move into offset binary
  function automatic logic [7:0] chroma_byte(input logic signed [18:0] acc);
    logic signed [10:0] v;
    v = acc[18:ypk_pkg::FRAC_BITS];
    v = (v < ypk_pkg::CHR_LO) ? ypk_pkg::CHR_LO : ((v > ypk_pkg::CHR_HI) ? ypk_pkg::CHR_HI : v);
    return v[7:0] + ypk_pkg::CHR_OFFSET;
  endfunction

  // =========================================================================
  // declarations
  logic accept;
  logic [10:0] col_next;
  logic [7:0] mem_rd;
  logic ready_q, ready_d;
  logic s1_valid_q, s1_valid_d;
  logic [10:0] col_q, col_d;
  logic rowpar_q, rowpar_d;
  logic row0_q, row0_d;
  logic mode_q, mode_d;
  logic [7:0] raw_q, raw_d;
  logic [7:0] left_q, left_d;
  logic [7:0] upprev_q, upprev_d;
  logic [7:0] win [4];
  logic [7:0] red, blue, green;
  logic [8:0] gsum;
  logic s2_valid_q, s2_valid_d;
  logic s2_odd_q, s2_odd_d;
  logic [7:0] y_q, y_d;
  logic [7:0] u_q, u_d;
  logic [7:0] v_q, v_d;
  ypk_pkg::ypk_ser_e ser_q, ser_d;
  logic [7:0] second_q, second_d;
  logic [7:0] v_hold_q, v_hold_d;
  logic byte_valid_q, byte_valid_d;
  logic [7:0] byte_q, byte_d;

  assign accept = i_pix_valid && ready_q;
  assign col_next = (i_pix_sof || i_pix_sol) ? ypk_pkg::COL_ZERO : col_q + ypk_pkg::COL_ONE;

  // =========================================================================
  // input tracking; ready drops for a cycle after each pixel since every
  // pixel needs two byte slots and there is no buffer to absorb a burst
  always_comb
  begin
    ready_d = !accept;
    s1_valid_d = accept;
    col_d = col_q;
    rowpar_d = rowpar_q;
    row0_d = row0_q;
    mode_d = mode_q;
    raw_d = raw_q;
    left_d = left_q;
    if (accept)
    begin
      raw_d = i_pix_data;
      left_d = raw_q;
      col_d = col_next;
      if (i_pix_sof)
      begin
        rowpar_d = 1'b0;
        row0_d = 1'b1;
        mode_d = i_fmt_yuyv; // order never changes mid-frame
      end
      else if (i_pix_sol)
      begin
        rowpar_d = !rowpar_q;
        row0_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ready_q <= 1'b1;
      s1_valid_q <= 1'b0;
      col_q <= ypk_pkg::COL_ZERO;
      rowpar_q <= 1'b0;
      row0_q <= 1'b1;
      mode_q <= 1'b0;
      raw_q <= 8'h00;
      left_q <= 8'h00;
    end
    else
    begin
      ready_q <= ready_d;
      s1_valid_q <= s1_valid_d;
      col_q <= col_d;
      rowpar_q <= rowpar_d;
      row0_q <= row0_d;
      mode_q <= mode_d;
      raw_q <= raw_d;
      left_q <= left_d;
    end
  end

  // previous line of raw samples, read one clock ahead of the window
  ypk_line_mem u_line (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_we(accept),
    .i_addr(col_next),
    .i_wdata(i_pix_data),
    .o_rdata(mem_rd)
  );

  // =========================================================================
  // 2x2 window demosaic; edges replicate the nearest sample, so the first
  // row and column carry some colour error
  always_comb
  begin
    upprev_d = s1_valid_q ? mem_rd : upprev_q;
    win[0] = raw_q;
    win[1] = (col_q == ypk_pkg::COL_ZERO) ? raw_q : left_q;
    win[2] = row0_q ? raw_q : mem_rd;
    win[3] = row0_q ? win[1] : ((col_q == ypk_pkg::COL_ZERO) ? mem_rd : upprev_q);
    red = 8'h00;
    blue = 8'h00;
    gsum = 9'h000;
    for (int k = 0; k < 4; k++)
    begin
      unique case (bayer_kind(rowpar_q ^ k[1], col_q[0] ^ k[0]))
        ypk_pkg::KIND_RED: red = win[k];
        ypk_pkg::KIND_BLUE: blue = win[k];
        ypk_pkg::KIND_GREEN: gsum = gsum + {1'b0, win[k]};
      endcase
    end
    green = 8'((gsum + 9'h001) >> 1); // two greens in every window
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      upprev_q <= 8'h00;
    else
      upprev_q <= upprev_d;
  end

  // =========================================================================
  // colour conversion with round-to-nearest and saturation
  always_comb
  begin
    s2_valid_d = s1_valid_q;
    s2_odd_d = col_q[0];
    y_d = y_q;
    u_d = u_q;
    v_d = v_q;
    if (s1_valid_q)
    begin
      y_d = luma_byte(mac(ypk_pkg::Y_R, ypk_pkg::Y_G, ypk_pkg::Y_B, red, green, blue));
      u_d = chroma_byte(mac(ypk_pkg::U_R, ypk_pkg::U_G, ypk_pkg::U_B, red, green, blue));
      v_d = chroma_byte(mac(ypk_pkg::V_R, ypk_pkg::V_G, ypk_pkg::V_B, red, green, blue));
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s2_valid_q <= 1'b0;
      s2_odd_q <= 1'b0;
      y_q <= 8'h00;
      u_q <= ypk_pkg::CHR_OFFSET;
      v_q <= ypk_pkg::CHR_OFFSET;
    end
    else
    begin
      s2_valid_q <= s2_valid_d;
      s2_odd_q <= s2_odd_d;
      y_q <= y_d;
      u_q <= u_d;
      v_q <= v_d;
    end
  end

  // =========================================================================
  // byte serialiser: each pixel yields two bytes; the odd pixel reuses the
  // red-difference byte held from its even partner
  always_comb
  begin
    ser_d = ypk_pkg::SER_IDLE;
    second_d = second_q;
    v_hold_d = v_hold_q;
    byte_valid_d = 1'b0;
    byte_d = byte_q;
    unique case (ser_q)
      ypk_pkg::SER_IDLE:
      begin
        if (s2_valid_q)
        begin
          ser_d = ypk_pkg::SER_SECOND;
          byte_valid_d = 1'b1;
          if (!s2_odd_q)
            v_hold_d = v_q;
          // standard: U0 Y0 then V0 Y1; alternate: Y0 U0 then Y1 V0
          byte_d = mode_q ? y_q : (s2_odd_q ? v_hold_q : u_q);
          second_d = mode_q ? (s2_odd_q ? v_hold_q : u_q) : y_q;
        end
      end
      ypk_pkg::SER_SECOND:
      begin
        byte_valid_d = 1'b1;
        byte_d = second_q;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ser_q <= ypk_pkg::SER_IDLE;
      second_q <= 8'h00;
      v_hold_q <= ypk_pkg::CHR_OFFSET;
      byte_valid_q <= 1'b0;
      byte_q <= 8'h00;
    end
    else
    begin
      ser_q <= ser_d;
      second_q <= second_d;
      v_hold_q <= v_hold_d;
      byte_valid_q <= byte_valid_d;
      byte_q <= byte_d;
    end
  end

  assign o_pix_ready = ready_q;
  assign o_byte_valid = byte_valid_q;
  assign o_byte_data = byte_q;

  // =========================================================================
  // assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  AST_RGB_PICK: assert property (
    s1_valid_q && !rowpar_q && !col_q[0] |-> blue == raw_q)
    else $error("blue site did not keep its own sample");
  AST_LUMA_GRAY: assert property (
    s1_valid_q && red == green && green == blue |=> y_q == $past(red))
    else $error("grey pixel luma differs from its level");
  AST_U_GRAY: assert property (
    s1_valid_q && red == green && green == blue |=> u_q == 8'h80)
    else $error("grey pixel blue-difference is not 0x80");
  AST_V_GRAY: assert property (
    s1_valid_q && red == green && green == blue |=> v_q == 8'h80)
    else $error("grey pixel red-difference is not 0x80");
  AST_U_SAT: assert property (
    s1_valid_q && red == 8'h00 && green == 8'h00 && blue == 8'hFF |=> u_q == 8'hFF)
    else $error("full blue did not saturate to 0xFF");
  AST_TWO_BYTES: assert property (
    s2_valid_q |=> o_byte_valid ##1 o_byte_valid ##1 o_byte_valid == $past(s2_valid_q))
    else $error("pixel did not give exactly two bytes");
  AST_STD_ORDER: assert property (
    s2_valid_q && !s2_odd_q && !mode_q |=> o_byte_data == $past(u_q) ##1 o_byte_data == $past(y_q, 2))
    else $error("standard order even pixel bytes wrong");
  AST_YUYV_ORDER: assert property (
    s2_valid_q && s2_odd_q && mode_q |=> o_byte_data == $past(y_q) ##1 o_byte_data == $past(v_hold_q, 2))
    else $error("alternate order odd pixel bytes wrong");

endmodule // ypk_packer

`default_nettype wire

// ---- test/ypk_host_sink.sv ----
/*
  Host image buffer model: collects every packed byte with the cycle it
  arrived in, for the bench to inspect.
  Assumes a single clock and no back-pressure towards the packer.
*/
`default_nettype none

module ypk_host_sink (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // packed byte stream
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // =========================================================================
  // capture store
  logic [7:0] byte_seen[$];
  int cyc_seen[$];
  int cyc = 0;

  // the buffer never stalls, so every valid cycle is one byte in memory
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cyc <= 0;
    else
    begin
      if (i_byte_valid)
      begin
        byte_seen.push_back(i_byte_data);
        cyc_seen.push_back(cyc); // edges before the one that saw the byte
      end
      cyc <= cyc + 1;
    end
  end

endmodule // ypk_host_sink

`default_nettype wire

// ---- test/ypk_packer_tb.sv ----
/*
  Self-checking bench for the 4:2:2 packer: colour-site frames in both orders.
  Assumes the design package and the host sink model are compiled first.
*/
`default_nettype none

module ypk_packer_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // =========================================================================
  // signals and counters
  localparam time DLY = 2ns;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_pix_valid = 1'b0;
  logic i_pix_sof = 1'b0;
  logic i_pix_sol = 1'b0;
  logic [7:0] i_pix_data = 8'h00;
  logic i_fmt_yuyv = 1'b0;
  logic o_pix_ready;
  logic o_byte_valid;
  logic [7:0] o_byte_data;
  int fail_count = 0;
  int n_checks = 0;

  // =========================================================================
  // clock, design and host model
  always #20 i_clk = ~i_clk;

  ypk_packer i_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_pix_valid(i_pix_valid), .i_pix_sof(i_pix_sof),
    .i_pix_sol(i_pix_sol), .i_pix_data(i_pix_data), .i_fmt_yuyv(i_fmt_yuyv),
    .o_pix_ready(o_pix_ready), .o_byte_valid(o_byte_valid), .o_byte_data(o_byte_data));

  ypk_host_sink i_host (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_byte_valid(o_byte_valid), .i_byte_data(o_byte_data));

  // =========================================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // reference conversion: 8.8 weights, round half up, clamp, then offset
  function automatic logic [7:0] cvt(input int cr, input int cg, input int cb, input int r,
                                     input int g, input int b, input int lo, input int hi, input int off);
    int s;
    s = (cr * r + cg * g + cb * b + 128) >>> 8;
    if (s < lo)
      s = lo;
    if (s > hi)
      s = hi;
    return 8'(s + off);
  endfunction

  // offer one pixel and hold it until ready lets it in
  task automatic send_px(input logic [7:0] d, input logic sof, input logic sol);
    i_pix_valid = 1'b1;
    i_pix_data = d;
    i_pix_sof = sof;
    i_pix_sol = sol;
    while (o_pix_ready !== 1'b1)
    begin
      @(posedge i_clk);
      #DLY;
    end
    @(posedge i_clk);
    #DLY;
    check(o_pix_ready, 1'b0);
  endtask

  // =========================================================================
  // scenario: two 4-pixel rows, every site of a colour holds one value;
  // only row 1 pair (2,3) sees a full window, unless the field is flat
  task automatic run_frame(input logic fmt, input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
    logic [7:0] px;
    logic [7:0] exp_b[4];
    int base;
    int first;
    y = cvt(ypk_pkg::Y_R, ypk_pkg::Y_G, ypk_pkg::Y_B, r, g, b, 0, 255, 0);
    u = cvt(ypk_pkg::U_R, ypk_pkg::U_G, ypk_pkg::U_B, r, g, b, -128, 127, 128);
    v = cvt(ypk_pkg::V_R, ypk_pkg::V_G, ypk_pkg::V_B, r, g, b, -128, 127, 128);
    if (fmt)
      exp_b = '{y, u, y, v};
    else
      exp_b = '{u, y, v, y};
    i_host.byte_seen.delete();
    i_host.cyc_seen.delete();
    i_fmt_yuyv = fmt;
    base = 0;
    for (int row = 0; row < 2; row++)
      for (int col = 0; col < 4; col++)
      begin
        px = (row == 0) ? (col[0] ? g : b) : (col[0] ? r : g);
        send_px(px, row == 0 && col == 0, col == 0);
        if (row == 0 && col == 0)
        begin
          base = i_host.cyc - 1; // edges before the accept edge
          i_fmt_yuyv = ~fmt; // order must stay as latched with the frame start
        end
      end
    i_pix_valid = 1'b0;
    i_pix_sof = 1'b0;
    i_pix_sol = 1'b0;
    repeat (8) @(posedge i_clk);
    #DLY;
    check(i_host.byte_seen.size(), 16);
    check(i_host.cyc_seen[0], base + 3);
    first = (r == g && g == b) ? 0 : 12;
    for (int i = first; i < 16; i++)
      check(i_host.byte_seen[i], exp_b[i % 4]);
    $display("frame test done, order %0d", fmt);
  endtask

  // =========================================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge i_clk);
    #DLY;
    i_rst_b = 1'b1;
    check(o_pix_ready, 1'b1);
    check(o_byte_valid, 1'b0);
    check(o_byte_data, 8'h00);
    $display("reset test done");
    run_frame(1'b0, 8'hFF, 8'h00, 8'h00);
    run_frame(1'b1, 8'h00, 8'h00, 8'hFF);
    run_frame(1'b0, 8'h00, 8'hFF, 8'h00);
    run_frame(1'b1, 8'h12, 8'hC8, 8'h5A);
    run_frame(1'b1, 8'hFF, 8'hFF, 8'hFF);
    run_frame(1'b0, 8'h00, 8'h00, 8'h00);
    end_of_test();
  end

  // six frames take well under 400 cycles; a hang is cut off long after
  initial
  begin
    repeat (2000) @(posedge i_clk);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

endmodule // ypk_packer_tb

`default_nettype wire
